//--- core/fcl_compare_unit.sv
// Compare unit: less-or-equal flag vector and less-than compare, with
// guard, sticky status word, interrupt and an APB register slave.
// Assumes an APB master on the core clock and other float units that
// report their exception updates on the shared flag port.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fcl_map.svh"

// Contract
// - Less-or-equal flags op returns the exception vector of first <= second.
// - Vector bit positions match the status word: invalid 0x10, flushed 0x20.
// - Less-or-equal flags op never alters the status word exception flags; it sets only the done bit.
// - Denormal operand compares as zero and sets flushed bit in vector.
// - Flags op with guard writes destination only when guard bit zero is one.
// - Less-or-equal flags runs as greater-or-equal flags with operands swapped.
// - Less-than compare runs as greater-than compare with operands swapped.
// - Less-than compare writes one when first is strictly smaller, else zero.
// - Less-than denormal operand compares as zero and sets flushed status flag.
// - Less-than exceptions set the matching status word flags.
// - Status flags are sticky; only an explicit status write clears them.
// - Less-than status update lands on the same edge as the destination.
// - Simultaneous status updates OR together with the existing flags.
// - Less-than with false guard changes neither destination nor status exception flags; done still sets.
module fcl_compare_unit #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [`FCL_WORD_W-1:0] pwdata,
  output logic [`FCL_WORD_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Exception updates from other float units
  input wire logic ext_flag_valid,
  input wire logic [`FCL_XFLAG_W-1:0] ext_flags,
  // Interrupt
  output logic irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************

  logic [`FCL_WORD_W-1:0] first_source_operand;
  logic [`FCL_WORD_W-1:0] second_source_operand;
  logic [`FCL_WORD_W-1:0] guard;
  logic [`FCL_WORD_W-1:0] dest;
  logic [`FCL_PSW_W-1:0] processor_status_word;
  logic [`FCL_PSW_W-1:0] mask;
  logic guard_used;
  logic last_result;
  fcl_pkg::fcl_op_t op;
  fcl_pkg::fcl_state_t state;

  logic [`FCL_WORD_W-1:0] next_dest;
  logic [`FCL_PSW_W-1:0] next_psw;
  logic [`FCL_WORD_W-1:0] next_rdata;
  logic [`FCL_WORD_W-1:0] flag_word;
  logic [`FCL_PSW_W-1:0] lt_set;

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  // The answer is held back one access cycle so that pready and the
  // read data both leave flip-flops.
  wire logic acc_first = psel && penable && !pready;
  wire logic wr_en = psel && penable && pready && pwrite;
  wire logic hit_opa = paddr == ADDR_W'(`FCL_OFF_OPA);
  wire logic hit_opb = paddr == ADDR_W'(`FCL_OFF_OPB);
  wire logic hit_guard = paddr == ADDR_W'(`FCL_OFF_GUARD);
  wire logic hit_ctrl = paddr == ADDR_W'(`FCL_OFF_CTRL);
  wire logic hit_dest = paddr == ADDR_W'(`FCL_OFF_DEST);
  wire logic hit_psw = paddr == ADDR_W'(`FCL_OFF_PSW);
  wire logic hit_mask = paddr == ADDR_W'(`FCL_OFF_MASK);
  wire logic hit_state = paddr == ADDR_W'(`FCL_OFF_STATE);
  wire logic hit_any = hit_opa || hit_opb || hit_guard || hit_ctrl ||
    hit_dest || hit_psw || hit_mask || hit_state;
  wire logic ctrl_wr = wr_en && hit_ctrl;
  wire logic psw_wr = wr_en && hit_psw;
  wire logic start = ctrl_wr && pwdata[`FCL_CTRL_START];

  // ****************************************************************
  // Compare datapath
  // ****************************************************************

  logic cmp_result;
  logic cmp_invalid;
  logic cmp_flushed;

  // Both forms feed the second operand as the left side, which turns
  // greater-or-equal into less-or-equal and greater into less.
  wire logic leq_mode = op == fcl_pkg::FCL_OP_LEQ_FLAGS;

  fcl_cmp_core u_core (
    .lhs(second_source_operand),
    .rhs(first_source_operand),
    .or_equal(leq_mode),
    .result(cmp_result),
    .invalid(cmp_invalid),
    .flushed(cmp_flushed)
  );

  // The guard gate covers the destination and, for the less-than
  // form, the status exception flags as well; the done bit is not gated.
  wire logic exec = state == fcl_pkg::FCL_EXEC;
  wire logic guard_ok = !guard_used || guard[0];
  wire logic commit = exec && guard_ok;
  wire logic lt_commit = commit && !leq_mode;
  wire logic [`FCL_PSW_W-1:0] ext_set = ext_flag_valid ?
    {{(`FCL_PSW_W-`FCL_XFLAG_W){1'b0}}, ext_flags} : `FCL_RESET_PSW;
  wire logic [`FCL_PSW_W-1:0] clear_bits = psw_wr ?
    pwdata[`FCL_PSW_W-1:0] : `FCL_RESET_PSW;

  // Flag vectors built from the comparator's exception outputs.
  always_comb
  begin
    flag_word = `FCL_RESET_WORD;
    flag_word[`FCL_BIT_INV] = cmp_invalid;
    flag_word[`FCL_BIT_IFZ] = cmp_flushed;
    lt_set = `FCL_RESET_PSW;
    lt_set[`FCL_BIT_INV] = lt_commit && cmp_invalid;
    lt_set[`FCL_BIT_IFZ] = lt_commit && cmp_flushed;
    lt_set[`FCL_BIT_DONE] = exec;
  end

  // Destination select; a false guard keeps the old value.
  always_comb
  begin
    next_dest = dest;
    if (commit && leq_mode)
    begin
      next_dest = flag_word;
    end
    else if (commit)
    begin
      next_dest = cmp_result ? `FCL_TRUE_WORD : `FCL_RESET_WORD;
    end
  end

  // Clear first, then OR every simultaneous update, so that a flag
  // raised in the cycle of its clear survives. The flags form adds
  // nothing here but the done event.
  always_comb
  begin
    next_psw = (processor_status_word & ~clear_bits) | lt_set | ext_set;
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************

  always_comb
  begin
    next_rdata = `FCL_RESET_WORD;
    case (1'b1)
      hit_opa: next_rdata = first_source_operand;
      hit_opb: next_rdata = second_source_operand;
      hit_guard: next_rdata = guard;
      hit_ctrl:
      begin
        next_rdata[`FCL_CTRL_OP] = !leq_mode;
        next_rdata[`FCL_CTRL_GUARD] = guard_used;
      end
      hit_dest: next_rdata = dest;
      hit_psw: next_rdata[`FCL_PSW_W-1:0] = processor_status_word;
      hit_mask: next_rdata[`FCL_PSW_W-1:0] = mask;
      hit_state:
      begin
        next_rdata[`FCL_STATE_BUSY] = exec;
        next_rdata[`FCL_STATE_RES] = last_result;
      end
      default: next_rdata = `FCL_RESET_WORD;
    endcase
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************

  // Unmapped addresses answer with an error and read as zero.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `FCL_RESET_WORD;
    end
    else
    begin
      pready <= acc_first;
      pslverr <= acc_first && !hit_any;
      prdata <= (acc_first && !pwrite) ? next_rdata : `FCL_RESET_WORD;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************

  // Operands, guard and mode are written only on the accepting edge.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      first_source_operand <= `FCL_RESET_WORD;
      second_source_operand <= `FCL_RESET_WORD;
      guard <= `FCL_RESET_WORD;
      mask <= `FCL_RESET_PSW;
      guard_used <= 1'b0;
      op <= fcl_pkg::FCL_OP_LEQ_FLAGS;
    end
    else
    begin
      if (wr_en && hit_opa)
        first_source_operand <= pwdata;
      if (wr_en && hit_opb)
        second_source_operand <= pwdata;
      if (wr_en && hit_guard)
        guard <= pwdata;
      if (wr_en && hit_mask)
        mask <= pwdata[`FCL_PSW_W-1:0];
      if (ctrl_wr)
      begin
        guard_used <= pwdata[`FCL_CTRL_GUARD];
        op <= fcl_pkg::fcl_op_t'(pwdata[`FCL_CTRL_OP]);
      end
    end
  end

  // ****************************************************************
  // Sequencer and results
  // ****************************************************************

  // One execute cycle per start; the bus cannot start again sooner
  // than three cycles later, so no start is ever lost while busy.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= fcl_pkg::FCL_IDLE;
      dest <= `FCL_RESET_WORD;
      processor_status_word <= `FCL_RESET_PSW;
      last_result <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      case (state)
        fcl_pkg::FCL_IDLE:
          state <= start ? fcl_pkg::FCL_EXEC : fcl_pkg::FCL_IDLE;
        fcl_pkg::FCL_EXEC:
          state <= fcl_pkg::FCL_IDLE;
        default:
          state <= fcl_pkg::FCL_IDLE;
      endcase
      dest <= next_dest;
      processor_status_word <= next_psw;
      if (exec)
        last_result <= cmp_result;
      irq <= |(next_psw & (wr_en && hit_mask ?
        pwdata[`FCL_PSW_W-1:0] : mask));
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  wire logic [`FCL_WORD_W-1:0] vec_mask = (`FCL_TRUE_WORD << `FCL_BIT_INV) |
    (`FCL_TRUE_WORD << `FCL_BIT_IFZ);

  flags_layout_a:
  assert property (@(posedge clk) disable iff (reset)
    exec && leq_mode && guard_ok |=> (dest & ~vec_mask) == `FCL_RESET_WORD)
    else $error("flag vector has bits outside invalid and flushed");

  flags_no_psw_a:
  assert property (@(posedge clk) disable iff (reset)
    exec && leq_mode && !ext_flag_valid |=>
      !$rose(processor_status_word[`FCL_BIT_INV]) &&
      !$rose(processor_status_word[`FCL_BIT_IFZ]))
    else $error("flags operation changed the status word");

  flags_flush_a:
  assert property (@(posedge clk) disable iff (reset)
    exec && leq_mode && guard_ok && cmp_flushed |=> dest[`FCL_BIT_IFZ])
    else $error("denormal input did not set flushed bit in vector");

  flags_guard_a:
  assert property (@(posedge clk) disable iff (reset)
    exec && leq_mode && !guard_ok |=> $stable(dest))
    else $error("false guard changed the destination");

  lt_equal_a:
  assert property (@(posedge clk) disable iff (reset)
    exec && !leq_mode && guard_ok &&
      first_source_operand == second_source_operand |=>
      dest == `FCL_RESET_WORD)
    else $error("equal operands compared as less");

  lt_flush_a:
  assert property (@(posedge clk) disable iff (reset)
    lt_commit && cmp_flushed |=> processor_status_word[`FCL_BIT_IFZ])
    else $error("denormal input did not set flushed status flag");

  lt_nan_a:
  assert property (@(posedge clk) disable iff (reset)
    lt_commit && cmp_invalid |=>
      processor_status_word[`FCL_BIT_INV] && dest == `FCL_RESET_WORD)
    else $error("NaN compare did not give zero and invalid");

  psw_sticky_a:
  assert property (@(posedge clk) disable iff (reset)
    processor_status_word[`FCL_BIT_INV] &&
      !(psw_wr && pwdata[`FCL_BIT_INV]) |=>
      processor_status_word[`FCL_BIT_INV])
    else $error("invalid flag cleared without a status write");

  psw_same_edge_a:
  assert property (@(posedge clk) disable iff (reset)
    $rose(processor_status_word[`FCL_BIT_INV]) &&
      !$past(ext_flag_valid) |-> $past(lt_commit))
    else $error("status flag rose without a committed compare");

  psw_or_a:
  assert property (@(posedge clk) disable iff (reset)
    ext_flag_valid |=>
      ((processor_status_word[`FCL_XFLAG_W-1:0] & $past(ext_flags)) ==
      $past(ext_flags)))
    else $error("simultaneous flag update was lost");

  lt_guard_a:
  assert property (@(posedge clk) disable iff (reset)
    exec && !leq_mode && !guard_ok && !ext_flag_valid |=>
      $stable(dest) && !$rose(processor_status_word[`FCL_BIT_INV]))
    else $error("false guard changed destination or status");

  nan_false_a:
  assert property (@(posedge clk) disable iff (reset)
    exec && guard_ok && cmp_invalid |=>
      (leq_mode ? dest[`FCL_BIT_INV] : dest == `FCL_RESET_WORD))
    else $error("NaN operand not reported as invalid");

  irq_level_a:
  assert property (@(posedge clk) disable iff (reset)
    irq == |(processor_status_word & mask))
    else $error("interrupt does not follow masked status");

  apb_ready_a:
  assert property (@(posedge clk) disable iff (reset)
    acc_first |=> pready ##1 !pready)
    else $error("access phase not answered after one wait cycle");

endmodule : fcl_compare_unit
`default_nettype wire

//--- core/fcl_map.svh
// Register offsets, field positions and reset values of the compare unit.
// Assumes byte addresses on an APB bus with 32-bit data.
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH

// Register byte offsets.
`define FCL_OFF_OPA 8'h00
`define FCL_OFF_OPB 8'h04
`define FCL_OFF_GUARD 8'h08
`define FCL_OFF_CTRL 8'h0c
`define FCL_OFF_DEST 8'h10
`define FCL_OFF_PSW 8'h14
`define FCL_OFF_MASK 8'h18
`define FCL_OFF_STATE 8'h1c

// Control register fields.
`define FCL_CTRL_OP 0
`define FCL_CTRL_GUARD 1
`define FCL_CTRL_START 2

// Status word fields; the exception bits match the returned flag vector.
`define FCL_BIT_INV 4
`define FCL_BIT_IFZ 5
`define FCL_BIT_DONE 8
`define FCL_PSW_W 9
`define FCL_XFLAG_W 8

// State register fields.
`define FCL_STATE_BUSY 0
`define FCL_STATE_RES 1

// Single-precision layout.
`define FCL_WORD_W 32
`define FCL_SIGN 31
`define FCL_EXP_HI 30
`define FCL_EXP_LO 23
`define FCL_MAN_HI 22
`define FCL_EXP_MAX 8'hff
`define FCL_EXP_ZERO 8'h00
`define FCL_MAN_ZERO 23'h000000
`define FCL_KEY_ZERO 32'h80000000

// Reset and constant words.
`define FCL_RESET_WORD 32'h00000000
`define FCL_RESET_PSW 9'h000
`define FCL_TRUE_WORD 32'h00000001

`endif

//--- core/fcl_pkg.sv
// Types shared by the compare unit files.
// Assumes nothing beyond a SystemVerilog compiler.
package fcl_pkg;

  // Sequencer states of the unit.
  typedef enum logic {FCL_IDLE, FCL_EXEC} fcl_state_t;

  // Operation selected by the control register.
  typedef enum logic {FCL_OP_LEQ_FLAGS, FCL_OP_LT} fcl_op_t;

endpackage : fcl_pkg

//--- core/fcl_cmp_core.sv
// Single-precision greater-than / greater-or-equal comparator.
// Assumes the caller swaps operands to build the less-than forms.
`timescale 1ns/1ps
`default_nettype none
`include "fcl_map.svh"

module fcl_cmp_core (
  // Operands
  input wire logic [`FCL_WORD_W-1:0] lhs,
  input wire logic [`FCL_WORD_W-1:0] rhs,
  input wire logic or_equal,
  // Results
  output logic result,
  output logic invalid,
  output logic flushed
);

  // ****************************************************************
  // Operand classification
  // ****************************************************************

  // Exponent and mantissa tests for NaN and denormal inputs.
  wire logic lhs_exp_max = lhs[`FCL_EXP_HI:`FCL_EXP_LO] == `FCL_EXP_MAX;
  wire logic rhs_exp_max = rhs[`FCL_EXP_HI:`FCL_EXP_LO] == `FCL_EXP_MAX;
  wire logic lhs_exp_min = lhs[`FCL_EXP_HI:`FCL_EXP_LO] == `FCL_EXP_ZERO;
  wire logic rhs_exp_min = rhs[`FCL_EXP_HI:`FCL_EXP_LO] == `FCL_EXP_ZERO;
  wire logic lhs_man_nz = lhs[`FCL_MAN_HI:0] != `FCL_MAN_ZERO;
  wire logic rhs_man_nz = rhs[`FCL_MAN_HI:0] != `FCL_MAN_ZERO;
  wire logic lhs_nan = lhs_exp_max && lhs_man_nz;
  wire logic rhs_nan = rhs_exp_max && rhs_man_nz;
  wire logic lhs_den = lhs_exp_min && lhs_man_nz;
  wire logic rhs_den = rhs_exp_min && rhs_man_nz;

  // ****************************************************************
  // Ordered keys
  // ****************************************************************

  // Zeros of either sign and flushed denormals share one key, so that
  // they compare equal; negatives invert to reverse their order.
  wire logic [`FCL_WORD_W-1:0] lhs_key = lhs_exp_min ? `FCL_KEY_ZERO :
    lhs[`FCL_SIGN] ? ~lhs : (lhs | `FCL_KEY_ZERO);
  wire logic [`FCL_WORD_W-1:0] rhs_key = rhs_exp_min ? `FCL_KEY_ZERO :
    rhs[`FCL_SIGN] ? ~rhs : (rhs | `FCL_KEY_ZERO);

  // An unordered pair is false whatever the relation.
  assign result = !(lhs_nan || rhs_nan) &&
    (or_equal ? (lhs_key >= rhs_key) : (lhs_key > rhs_key));
  assign invalid = lhs_nan || rhs_nan;
  assign flushed = lhs_den || rhs_den;

endmodule : fcl_cmp_core
`default_nettype wire

//--- sim/fcl_flag_src.sv
// Model of the other float units that report exception updates.
// Assumes the bench holds fire for one or more cycles with a flag pattern.
`timescale 1ns/1ps
`default_nettype none

module fcl_flag_src (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bench command
  input wire logic fire,
  input wire logic [7:0] pattern,
  // Exception update port
  output logic ext_flag_valid,
  output logic [7:0] ext_flags
);
  // One update per cycle of fire; idle flags keep changing so a unit that
  // ignores the valid bit picks up garbage.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ext_flag_valid <= 1'b0;
      ext_flags <= 8'h00;
    end
    else if (fire)
    begin
      ext_flag_valid <= 1'b1;
      ext_flags <= pattern;
    end
    else
    begin
      ext_flag_valid <= 1'b0;
      ext_flags <= ~ext_flags;
    end
  end
endmodule : fcl_flag_src

`default_nettype wire

//--- sim/tb.sv
// Self-checking bench of the compare unit.
// Assumes the unit answers APB in bounded time and the flag source model.
`timescale 1ns/1ps
`default_nettype none
`include "fcl_map.svh"

module tb;
  logic clk, reset, psel, penable, pwrite, fire, pready, pslverr, irq;
  logic [7:0] paddr, pattern, ext_flags;
  logic [31:0] pwdata, prdata, q;
  logic ext_flag_valid, e;
  int err_count, compares;
  // Operand table: first, second, flag vector, less-than result.
  logic [31:0] ta [8] = '{32'h40400000, 32'h40400000, 32'h3f800000,
    32'h40400000, 32'h40400000, 32'h7f800000, 32'h3f800000, 32'h7f800000};
  logic [31:0] tb2 [8] = '{32'h0, 32'h40400000, 32'h40400000,
    32'h3f800000, 32'hffffffff, 32'hff800000, 32'h00400000, 32'h7f800000};
  logic [31:0] tf [8] = '{0, 0, 0, 0, 32'h10, 0, 32'h20, 0};
  logic [31:0] tl [8] = '{0, 0, 1, 0, 0, 0, 0, 0};

  fcl_compare_unit #(.ADDR_W(8)) fcl_compare_unit_inst (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_flag_valid(ext_flag_valid),
    .ext_flags(ext_flags), .irq(irq));
  fcl_flag_src fcl_flag_src_inst (.clk(clk), .reset(reset), .fire(fire),
    .pattern(pattern), .ext_flag_valid(ext_flag_valid),
    .ext_flags(ext_flags));

  // Clock of 50 ns.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  // One APB transfer; waits for pready without assuming a latency.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1);
  endtask : apb

  // Loads operands and guard, then starts one operation.
  task automatic run(input logic [31:0] a, input logic [31:0] b,
                     input logic lt, input logic gu, input logic [31:0] g);
    apb(1'b1, `FCL_OFF_OPA, a);
    apb(1'b1, `FCL_OFF_OPB, b);
    apb(1'b1, `FCL_OFF_GUARD, g);
    apb(1'b1, `FCL_OFF_CTRL, {29'h0, 1'b1, gu, lt});
  endtask : run

  task automatic t_reset;
    apb(1'b0, `FCL_OFF_PSW, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `FCL_OFF_DEST, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `FCL_OFF_DEST, 32'hffff);
    apb(1'b0, `FCL_OFF_DEST, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_flags;
    for (int i = 0; i < 8; i++)
    begin
      run(ta[i], tb2[i], 1'b0, i == 2, 32'h1);
      apb(1'b0, `FCL_OFF_DEST, 32'h0);
      chk(q, tf[i]);
      apb(1'b0, `FCL_OFF_PSW, 32'h0);
      chk(q, 32'h100);
    end
    // Guard with bit zero clear but a higher bit set must not write.
    run(32'h40400000, 32'hffffffff, 1'b0, 1'b0, 32'h1);
    run(32'h3f800000, 32'h40400000, 1'b0, 1'b1, 32'h2);
    apb(1'b0, `FCL_OFF_DEST, 32'h0);
    chk(q, 32'h10);
    apb(1'b0, `FCL_OFF_CTRL, 32'h0);
    chk(q, 32'h2);
    $display("test flags done");
  endtask : t_flags

  task automatic t_less;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, `FCL_OFF_PSW, 32'h1ff);
      run(ta[i], tb2[i], 1'b1, i == 2, 32'h1);
      apb(1'b0, `FCL_OFF_DEST, 32'h0);
      chk(q, tl[i]);
      apb(1'b0, `FCL_OFF_STATE, 32'h0);
      chk(q, {30'h0, tl[i][0], 1'b0});
      apb(1'b0, `FCL_OFF_PSW, 32'h0);
      chk(q, 32'h100 | (i == 4 ? 32'h10 : 0) | (i == 6 ? 32'h20 : 0));
    end
    run(32'hff800000, 32'h7f800000, 1'b1, 1'b0, 32'h0);
    apb(1'b0, `FCL_OFF_DEST, 32'h0);
    chk(q, 32'h1);
    // Flags stay set across a clean compare.
    run(32'h40400000, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    run(32'h3f800000, 32'h40400000, 1'b1, 1'b0, 32'h0);
    apb(1'b0, `FCL_OFF_PSW, 32'h0);
    chk(q, 32'h110);
    // Unguarded this pair would write zero and raise the flushed flag.
    run(32'h3f800000, 32'h00400000, 1'b1, 1'b1, 32'h0);
    apb(1'b0, `FCL_OFF_DEST, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, `FCL_OFF_PSW, 32'h0);
    chk(q, 32'h110);
    $display("test less done");
  endtask : t_less

  task automatic t_irq;
    apb(1'b1, `FCL_OFF_PSW, 32'h1ff);
    apb(1'b1, `FCL_OFF_MASK, 32'h100);
    run(32'h40400000, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `FCL_OFF_MASK, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0);
    // Hold an outside update across a compare so both land on one edge.
    apb(1'b1, `FCL_OFF_PSW, 32'h1ff);
    fire <= 1'b1;
    pattern <= 8'h04;
    run(32'h40400000, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    @(posedge clk);
    fire <= 1'b0;
    apb(1'b0, `FCL_OFF_PSW, 32'h0);
    chk(q, 32'h114);
    apb(1'b1, `FCL_OFF_MASK, 32'h04);
    #1;
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `FCL_OFF_MASK, 32'h0);
    chk(q, 32'h4);
    apb(1'b1, `FCL_OFF_PSW, 32'h04);
    #1;
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the fewer than a thousand cycles the tests need.
  initial
  begin
    #1000000;
    err_count++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    err_count = 0;
    compares = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 1'b0;
    pattern = 8'h00;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_flags();
    t_less();
    t_irq();
    end_of_test();
  end
endmodule : tb

`default_nettype wire
